// ==== design/uart_tx_break_collision_pkg.sv ====
package uart_tx_break_collision_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // timing constants
  localparam int unsigned RT_PER_BIT = 16;
  localparam logic [3:0] RT_LAST_PHASE = 4'hF;
  localparam logic [3:0] TX_XFER_PHASE = 4'h9;
  localparam logic [3:0] SAMPLE_PHASE = 4'h8;
  localparam logic [3:0] FRAME_LEN_EIGHT = 4'hA;
  localparam logic [3:0] FRAME_LEN_NINE = 4'hB;
  localparam logic [3:0] MARK_LEN = 4'h1;
  localparam logic [3:0] ZERO_RUN_MAX = 4'hF;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [12:0] BAUD_DIV_RST = 13'h0000;
  localparam logic [10:0] SHIFT_RST = 11'h07FF;
  localparam logic [8:0] RX_DATA_RST = 9'h000;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  localparam logic [1:0] BERR_MODE_A = 2'h1;
  localparam logic [1:0] BERR_MODE_B = 2'h2;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_DATA = 3'b001,
    TX_IDLE_CHAR = 3'b010,
    TX_BREAK = 3'b011,
    TX_MARK = 3'b100
  } tx_kind_e;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_FRAME = 2'b01,
    RX_LOW_WAIT = 2'b10
  } rx_state_e;

  typedef struct packed {
    logic char_nine;
    logic parity_en;
    logic parity_odd;
    logic tx_enable_bit;
    logic send_break_bit;
    logic tx_irq_enable;
    logic break_detect_enable;
    logic [1:0] bit_error_mode;
    logic tx_polarity;
    logic rx_polarity;
  } cfg_s;

  typedef struct packed {
    logic [8:0] data;
    logic rx_buffer_full_flag;
    logic framing_error_flag;
    logic parity_error_flag;
    logic break_detected_flag;
    logic rx_active_flag;
  } rx_status_s;

endpackage : uart_tx_break_collision_pkg

// ==== design/uart_tx_break_collision.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - 8 or 9 bit characters, ninth from register
// - start 0 low, stop 1 high
// - buffer empty on transfer, raises irq
// - back-to-back transfer 9/16 into stop
// - empty flag resets set; write clears
// - zero divisor stops; high needs low write
// - enable rise sends 10/11 ones preamble
// - parity replaces character msb when enabled
// - line idles at logic one
// - enable cleared mid-frame finishes frame
// - enable toggle mid-frame queues idle character
// - break zeros repeat; then at least one
// - break is 10/11 consecutive received zeros
// - no detect: framing, full, data cleared
// - detect mode: only break flag set
// - mid-character break: partial byte, then flag
// - mode 01/10 compares tx and rx bits
// - mismatch aborts, flags set, blocks transmission
// - detection disabled holds bit error clear
// - one bit per sixteen divider ticks
module uart_tx_break_collision (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire uart_tx_break_collision_pkg::cfg_s i_cfg,
  input wire logic i_baud_high_wr,
  input wire logic [4:0] i_baud_high,
  input wire logic i_baud_low_wr,
  input wire logic [7:0] i_baud_low,
  input wire logic i_data_wr,
  input wire logic [7:0] i_data_low,
  input wire logic i_tx_ninth_bit,
  input wire logic i_bit_error_clr,
  input wire logic i_rx_flags_clr,
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_txd_oe,
  output logic o_tx_buffer_empty_flag,
  output logic o_tx_complete_flag,
  output logic o_tx_irq,
  output logic o_bit_error_flag,
  output uart_tx_break_collision_pkg::rx_status_s o_rx_status
);
  import uart_tx_break_collision_pkg::*;

  function automatic logic [3:0] frame_len(input logic nine);
    frame_len = nine ? FRAME_LEN_NINE : FRAME_LEN_EIGHT;
  endfunction : frame_len

  function automatic logic [10:0] build_frame(input logic [7:0] lo, input logic b8, input cfg_s c);
    logic [8:0] d;
    d = {b8, lo};
    if (c.char_nine)
    begin
      if (c.parity_en)
        d[8] = (^lo) ^ c.parity_odd;
      build_frame = {1'b1, d, 1'b0};
    end
    else
    begin
      if (c.parity_en)
        d[7] = (^lo[6:0]) ^ c.parity_odd;
      build_frame = {2'b11, d[7:0], 1'b0};
    end
  endfunction : build_frame

  ////////////////////////////////////////////////////////////////////////////////
  // baud generator
  logic [4:0] baud_high_pend_r;
  logic [12:0] baud_div_r;
  logic [12:0] baud_cnt_r;
  logic rt_tick_r;

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      baud_high_pend_r <= 5'h00;
      baud_div_r <= BAUD_DIV_RST;
    end
    else
    begin
      if (i_baud_high_wr)
        baud_high_pend_r <= i_baud_high;
      // high half alone does nothing until the low half lands
      if (i_baud_low_wr)
        baud_div_r <= {i_baud_high_wr ? i_baud_high : baud_high_pend_r, i_baud_low};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      baud_cnt_r <= BAUD_DIV_RST;
      rt_tick_r <= 1'b0;
    end
    else if (baud_div_r == BAUD_DIV_RST)
    begin
      baud_cnt_r <= BAUD_DIV_RST;
      rt_tick_r <= 1'b0;
    end
    else if (baud_cnt_r >= baud_div_r - 13'h0001)
    begin
      baud_cnt_r <= BAUD_DIV_RST;
      rt_tick_r <= 1'b1;
    end
    else
    begin
      baud_cnt_r <= baud_cnt_r + 13'h0001;
      rt_tick_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive line synchroniser
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_s3_r;
  logic rx_stable_r;
  logic rx_level;

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_stable_r <= 1'b1;
    end
    else
    begin
      rx_s1_r <= i_rxd;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_s2_r == rx_s3_r)
        rx_stable_r <= rx_s3_r;
    end
  end

  assign rx_level = rx_stable_r ^ i_cfg.rx_polarity;

  ////////////////////////////////////////////////////////////////////////////////
  // transmitter
  tx_kind_e tx_kind_r;
  logic [10:0] shift_r;
  logic [3:0] bits_left_r;
  logic [3:0] tx_phase_r;
  logic [7:0] buf_low_r;
  logic buf_ninth_r;
  logic [10:0] next_frame_r;
  logic next_valid_r;
  logic idle_pend_r;
  logic te_prev_r;
  logic tx_buffer_empty_flag_r;
  logic tc_r;
  logic berr_r;
  logic berr_en;
  logic tx_active;
  logic bit_end;
  logic mismatch;

  assign berr_en = (i_cfg.bit_error_mode == BERR_MODE_A) || (i_cfg.bit_error_mode == BERR_MODE_B);
  assign tx_active = (tx_kind_r != TX_IDLE);
  assign bit_end = rt_tick_r && (tx_phase_r == RT_LAST_PHASE);
  // compare at the mid-bit sample point, only while shifting
  assign mismatch = berr_en && tx_active && rt_tick_r && (tx_phase_r == SAMPLE_PHASE)
                    && (rx_level != shift_r[0]);

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      buf_low_r <= 8'h00;
      buf_ninth_r <= 1'b0;
    end
    else if (i_data_wr)
    begin
      buf_low_r <= i_data_low;
      buf_ninth_r <= i_tx_ninth_bit;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      te_prev_r <= 1'b0;
    else
      te_prev_r <= i_cfg.tx_enable_bit;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tx_kind_r <= TX_IDLE;
      shift_r <= SHIFT_RST;
      bits_left_r <= 4'h0;
      tx_phase_r <= 4'h0;
      next_frame_r <= SHIFT_RST;
      next_valid_r <= 1'b0;
      idle_pend_r <= 1'b0;
      tx_buffer_empty_flag_r <= 1'b1;
      tc_r <= 1'b1;
      berr_r <= 1'b0;
    end
    else
    begin
      if (i_data_wr)
        tx_buffer_empty_flag_r <= 1'b0;
      if (i_cfg.tx_enable_bit && !te_prev_r)
        idle_pend_r <= 1'b1;
      if (rt_tick_r && tx_active)
        tx_phase_r <= tx_phase_r + 4'h1;
      // stage the next frame 9/16 into the current stop bit
      if (rt_tick_r && tx_kind_r == TX_DATA && bits_left_r == 4'h1 && tx_phase_r == TX_XFER_PHASE - 4'h1
          && !tx_buffer_empty_flag_r && !i_data_wr && !next_valid_r && i_cfg.tx_enable_bit && !berr_r)
      begin
        next_frame_r <= build_frame(buf_low_r, buf_ninth_r, i_cfg);
        next_valid_r <= 1'b1;
        tx_buffer_empty_flag_r <= 1'b1;
      end
      if (mismatch && !berr_r)
      begin
        tx_kind_r <= TX_IDLE; // line falls back to recessive
        shift_r <= SHIFT_RST;
        next_valid_r <= 1'b0;
        idle_pend_r <= 1'b0;
        tx_buffer_empty_flag_r <= 1'b1;
        tc_r <= 1'b1;
        berr_r <= 1'b1;
      end
      else if (bit_end && bits_left_r > 4'h1)
      begin
        shift_r <= {1'b1, shift_r[10:1]};
        bits_left_r <= bits_left_r - 4'h1;
      end
      else if ((bit_end || (!tx_active && rt_tick_r)) && !berr_r)
      begin
        tx_phase_r <= 4'h0;
        if (!i_cfg.tx_enable_bit)
        begin
          tx_kind_r <= TX_IDLE;
          shift_r <= SHIFT_RST;
          tc_r <= 1'b1;
        end
        else if (i_cfg.send_break_bit)
        begin
          tx_kind_r <= TX_BREAK;
          shift_r <= 11'h000;
          bits_left_r <= frame_len(i_cfg.char_nine);
          tc_r <= 1'b0;
        end
        else if (tx_kind_r == TX_BREAK)
        begin
          tx_kind_r <= TX_MARK;
          shift_r <= SHIFT_RST;
          bits_left_r <= MARK_LEN;
        end
        else if (idle_pend_r)
        begin
          tx_kind_r <= TX_IDLE_CHAR;
          shift_r <= SHIFT_RST;
          bits_left_r <= frame_len(i_cfg.char_nine);
          idle_pend_r <= (i_cfg.tx_enable_bit && !te_prev_r);
          tc_r <= 1'b0;
        end
        else if (next_valid_r)
        begin
          tx_kind_r <= TX_DATA;
          shift_r <= next_frame_r;
          bits_left_r <= frame_len(i_cfg.char_nine);
          next_valid_r <= 1'b0;
          tc_r <= 1'b0;
        end
        else if (!tx_buffer_empty_flag_r && !i_data_wr)
        begin
          tx_kind_r <= TX_DATA;
          shift_r <= build_frame(buf_low_r, buf_ninth_r, i_cfg);
          bits_left_r <= frame_len(i_cfg.char_nine);
          tx_buffer_empty_flag_r <= 1'b1;
          tc_r <= 1'b0;
        end
        else
        begin
          tx_kind_r <= TX_IDLE;
          shift_r <= SHIFT_RST;
          tc_r <= 1'b1;
        end
      end
      // hardware set beats a software clear in the same cycle
      if (!berr_en)
        berr_r <= 1'b0;
      else if (i_bit_error_clr && !(mismatch && !berr_r))
        berr_r <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_txd <= 1'b1;
      o_txd_oe <= 1'b0;
      o_tx_buffer_empty_flag <= 1'b1;
      o_tx_complete_flag <= 1'b1;
      o_tx_irq <= 1'b0;
      o_bit_error_flag <= 1'b0;
    end
    else
    begin
      o_txd <= (tx_active ? shift_r[0] : 1'b1) ^ i_cfg.tx_polarity;
      o_txd_oe <= i_cfg.tx_enable_bit || tx_active;
      o_tx_buffer_empty_flag <= tx_buffer_empty_flag_r;
      o_tx_complete_flag <= tc_r;
      o_tx_irq <= tx_buffer_empty_flag_r && i_cfg.tx_irq_enable;
      o_bit_error_flag <= berr_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receiver: framing and break recognition
  rx_state_e rx_state_r;
  logic [3:0] rx_phase_r;
  logic [3:0] rx_bit_r;
  logic [3:0] zero_run_r;
  logic [8:0] rx_sh_r;
  logic brk_done_r;
  logic rx_sample;
  logic [3:0] zero_run_nxt;
  logic [8:0] rx_word;
  logic rx_par_err;

  assign rx_sample = rt_tick_r && (rx_phase_r == SAMPLE_PHASE);
  assign zero_run_nxt = rx_level ? 4'h0 : ((zero_run_r == ZERO_RUN_MAX) ? zero_run_r : zero_run_r + 4'h1);
  assign rx_word = i_cfg.char_nine ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
  assign rx_par_err = i_cfg.parity_en &&
                      (((i_cfg.char_nine ? ^rx_word : ^rx_word[7:0])) != i_cfg.parity_odd);

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_state_r <= RX_HUNT;
      rx_phase_r <= 4'h0;
      rx_bit_r <= 4'h0;
      zero_run_r <= 4'h0;
      rx_sh_r <= RX_DATA_RST;
      brk_done_r <= 1'b0;
      o_rx_status <= '0;
    end
    else
    begin
      if (i_rx_flags_clr)
      begin
        o_rx_status.rx_buffer_full_flag <= 1'b0;
        o_rx_status.framing_error_flag <= 1'b0;
        o_rx_status.parity_error_flag <= 1'b0;
        o_rx_status.break_detected_flag <= 1'b0;
      end
      o_rx_status.rx_active_flag <= (rx_state_r != RX_HUNT);
      if (rt_tick_r && rx_state_r != RX_HUNT)
        rx_phase_r <= rx_phase_r + 4'h1;
      case (rx_state_r)
        RX_HUNT:
        begin
          if (rt_tick_r && !rx_level)
          begin
            rx_state_r <= RX_FRAME;
            rx_phase_r <= 4'h0;
            rx_bit_r <= 4'h0;
            zero_run_r <= 4'h0;
          end
        end
        RX_FRAME:
        begin
          if (rx_sample)
          begin
            zero_run_r <= zero_run_nxt;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0 && rx_level)
              rx_state_r <= RX_HUNT;
            else if (rx_bit_r < frame_len(i_cfg.char_nine) - 4'h1)
            begin
              if (rx_bit_r != 4'h0)
                rx_sh_r <= {rx_level, rx_sh_r[8:1]};
            end
            else if (rx_level)
            begin
              o_rx_status.data <= rx_word;
              o_rx_status.rx_buffer_full_flag <= 1'b1;
              o_rx_status.parity_error_flag <= rx_par_err;
              rx_state_r <= RX_HUNT;
            end
            else if (zero_run_nxt >= frame_len(i_cfg.char_nine))
            begin
              rx_state_r <= RX_LOW_WAIT;
              brk_done_r <= 1'b1;
              if (i_cfg.break_detect_enable)
                o_rx_status.break_detected_flag <= 1'b1;
              else
              begin
                o_rx_status.data <= RX_DATA_RST;
                o_rx_status.rx_buffer_full_flag <= 1'b1;
                o_rx_status.framing_error_flag <= 1'b1;
              end
            end
            else
            begin
              // stop bit missing: partial character still delivered
              o_rx_status.data <= rx_word;
              o_rx_status.rx_buffer_full_flag <= 1'b1;
              o_rx_status.framing_error_flag <= 1'b1;
              o_rx_status.parity_error_flag <= rx_par_err;
              rx_state_r <= RX_LOW_WAIT;
              brk_done_r <= 1'b0;
            end
          end
        end
        RX_LOW_WAIT:
        begin
          // keep counting low bit times so a late break is still seen
          if (rx_sample)
          begin
            zero_run_r <= zero_run_nxt;
            if (rx_level)
              rx_state_r <= RX_HUNT;
            else if (!brk_done_r && zero_run_nxt >= frame_len(i_cfg.char_nine))
            begin
              brk_done_r <= 1'b1;
              if (i_cfg.break_detect_enable)
                o_rx_status.break_detected_flag <= 1'b1;
            end
          end
        end
        default:
        begin
          rx_state_r <= RX_HUNT;
        end
      endcase
    end
  end

endmodule : uart_tx_break_collision

// ==== test/lin_bus_node.sv ====
`timescale 1ns/10ps
module lin_bus_node (
  input wire logic i_txd,
  input wire logic i_node_low,
  output logic o_bus
);
  // wired-and bus with pull-up; both ends use the same polarity, non-inverted except in the t_collision idle check
  assign o_bus = i_txd & !i_node_low;
endmodule : lin_bus_node

// ==== test/uart_tx_break_collision_chk.sv ====
`timescale 1ns/10ps
module uart_tx_break_collision_chk (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire uart_tx_break_collision_pkg::cfg_s i_cfg,
  input wire logic i_bit_error_clr,
  input wire logic o_txd,
  input wire logic o_txd_oe,
  input wire logic o_tx_buffer_empty_flag,
  input wire logic o_tx_complete_flag,
  input wire logic o_tx_irq,
  input wire logic o_bit_error_flag,
  input wire uart_tx_break_collision_pkg::rx_status_s o_rx_status
);
  import uart_tx_break_collision_pkg::*;
  default clocking dc @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  logic berr_on;
  assign berr_on = i_cfg.bit_error_mode == BERR_MODE_A || i_cfg.bit_error_mode == BERR_MODE_B;
  ////////////////////////////////////////
  AST_IDLE_LEVEL: assert property (!o_txd_oe && $stable(i_cfg.tx_polarity) |-> o_txd == !i_cfg.tx_polarity)
    else $error("line not idle");
  AST_OE_HELD: assert property (i_cfg.tx_enable_bit |=> o_txd_oe)
    else $error("line released");
  AST_DONE_IDLE: assert property (!o_txd_oe && !$past(o_txd_oe) |-> o_tx_complete_flag)
    else $error("complete low while idle");
  AST_IRQ_SET: assert property ((i_cfg.tx_irq_enable && o_tx_buffer_empty_flag)[*2] |-> o_tx_irq)
    else $error("irq missing");
  AST_IRQ_MASK: assert property ((!i_cfg.tx_irq_enable)[*2] |-> !o_tx_irq)
    else $error("irq not masked");
  AST_BERR_OFF: assert property ((!berr_on)[*3] |-> !o_bit_error_flag)
    else $error("bit error while off");
  AST_BERR_HOLD: assert property (o_bit_error_flag && berr_on && !i_bit_error_clr && !$past(i_bit_error_clr)
    |=> o_bit_error_flag)
    else $error("bit error lost");
  AST_BERR_ABORT: assert property ($rose(o_bit_error_flag)
    |-> ##[0:2] (o_tx_buffer_empty_flag && o_tx_complete_flag))
    else $error("abort flags missing");
  AST_BERR_RECESSIVE: assert property (o_bit_error_flag && $past(o_bit_error_flag, 2)
    && $stable(i_cfg.tx_polarity) |-> o_txd == !i_cfg.tx_polarity)
    else $error("line not recessive");
  AST_BREAK_MODE: assert property ($rose(o_rx_status.break_detected_flag) |-> $past(i_cfg.break_detect_enable))
    else $error("break flag while off");
  AST_FRAME_FULL: assert property ($rose(o_rx_status.framing_error_flag) |-> o_rx_status.rx_buffer_full_flag)
    else $error("framing without full");
endmodule : uart_tx_break_collision_chk

bind uart_tx_break_collision uart_tx_break_collision_chk i_uart_tx_break_collision_chk (
  .i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b),
  .i_cfg(i_cfg),
  .i_bit_error_clr(i_bit_error_clr),
  .o_txd(o_txd),
  .o_txd_oe(o_txd_oe),
  .o_tx_buffer_empty_flag(o_tx_buffer_empty_flag),
  .o_tx_complete_flag(o_tx_complete_flag),
  .o_tx_irq(o_tx_irq),
  .o_bit_error_flag(o_bit_error_flag),
  .o_rx_status(o_rx_status)
);

// ==== test/uart_tx_break_collision_tb_top.sv ====
`timescale 1ns/10ps
module uart_tx_break_collision_tb_top;
  import uart_tx_break_collision_pkg::*;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  cfg_s cfg = '0;
  logic bh_wr = 1'h0, bl_wr = 1'h0, d_wr = 1'h0, n9 = 1'h0, be_clr = 1'h0, rx_clr = 1'h0, node_low = 1'h0;
  logic [4:0] bh = 5'h00;
  logic [7:0] bl = 8'h00, dl = 8'h00;
  logic txd, oe, empty, done, irq, berr, bus;
  rx_status_s rx;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  uart_tx_break_collision i_uart_tx_break_collision (.i_core_clk(clk), .i_rst_b(rst_b), .i_cfg(cfg),
    .i_baud_high_wr(bh_wr), .i_baud_high(bh), .i_baud_low_wr(bl_wr), .i_baud_low(bl), .i_data_wr(d_wr),
    .i_data_low(dl), .i_tx_ninth_bit(n9), .i_bit_error_clr(be_clr), .i_rx_flags_clr(rx_clr), .i_rxd(bus),
    .o_txd(txd), .o_txd_oe(oe), .o_tx_buffer_empty_flag(empty), .o_tx_complete_flag(done), .o_tx_irq(irq),
    .o_bit_error_flag(berr), .o_rx_status(rx));
  lin_bus_node i_lin_bus_node (.i_txd(txd), .i_node_low(node_low), .o_bus(bus));
  ////////////////////////////////////////
  task automatic complete_run;
    if (fails == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_ok(input logic ok);
    num_checks++;
    if (ok !== 1'h1)
    begin
      fails++;
      $display("Error %0t: timing off", $time);
    end
  endtask : chk_ok
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      complete_run();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask : pulse
  task automatic wr_data(input logic [8:0] d);
    {n9, dl} = d;
    pulse(d_wr);
  endtask : wr_data
  task automatic set_enable(input logic v);
    cfg.tx_enable_bit = v;
    tick(1);
  endtask : set_enable
  // bounded so a stuck line ends as a mismatch, not a hang
  task automatic wait_for(ref logic s, input logic v, inout int t);
    while (s !== v && t < 3000)
    begin
      tick(1);
      t++;
    end
    chk_ok(t < 3000);
  endtask : wait_for
  task automatic count_low(input int n, output int k);
    k = 0;
    repeat (n)
    begin
      tick(1);
      if (txd !== 1'h1)
        k++;
    end
  endtask : count_low
  // samples mid-bit, lsb first, 16 clocks per bit at divisor one
  task automatic get_frame(input int n, output logic [15:0] f);
    f = '0;
    tick(8);
    for (int i = 0; i < n; i++)
    begin
      f[i] = txd;
      tick(16);
    end
  endtask : get_frame
  ////////////////////////////////////////
  task automatic t_divisor;
    logic [15:0] f;
    int t;
    int k;
    set_enable(1'h1);
    wr_data(9'h0A5);
    tick(1);
    chk(16'(empty), 16'h0000);
    bh = 5'h01;
    pulse(bh_wr);
    count_low(400, k);
    chk(16'(k), 16'h0000);
    bh = 5'h00;
    bl = 8'h01;
    bh_wr = 1'h1;
    bl_wr = 1'h1;
    tick(1);
    bh_wr = 1'h0;
    bl_wr = 1'h0;
    t = 0;
    wait_for(txd, 1'h0, t);
    chk_ok(t >= 156 && t <= 184);
    get_frame(10, f);
    chk(f, 16'h034A);
    tick(24);
    set_enable(1'h0);
  endtask : t_divisor
  task automatic t_formats;
    logic [2:0] sel [5] = '{3'h0, 3'h4, 3'h2, 3'h3, 3'h7};
    logic [8:0] d;
    logic [15:0] f;
    int len;
    int t;
    for (int k = 0; k < 5; k++)
    begin
      {cfg.char_nine, cfg.parity_en, cfg.parity_odd} = sel[k];
      d = 9'h1B3;
      len = sel[k][2] ? 11 : 10;
      if (sel[k][1] && sel[k][2])
        d[8] = ^d[7:0] ^ sel[k][0];
      else if (sel[k][1])
        d[7] = ^d[6:0] ^ sel[k][0];
      set_enable(1'h1);
      wr_data(9'h1B3);
      t = 0;
      wait_for(txd, 1'h0, t);
      chk_ok(t >= len * 16 - 4 && t <= len * 16 + 24);
      cfg.tx_enable_bit = 1'h0;
      get_frame(len, f);
      chk(f, sel[k][2] ? {5'h00, 1'h1, d, 1'h0} : {6'h00, 1'h1, d[7:0], 1'h0});
      tick(24);
      chk(16'({oe, done, txd}), 16'h0003);
    end
  endtask : t_formats
  task automatic t_backtoback;
    logic [15:0] f;
    int t;
    cfg = '0;
    cfg.tx_irq_enable = 1'h1;
    set_enable(1'h1);
    wr_data(9'h03C);
    t = 0;
    wait_for(txd, 1'h0, t);
    wr_data(9'h0C3);
    tick(2);
    chk(16'({empty, irq}), 16'h0000);
    t = 3;
    wait_for(empty, 1'h1, t);
    chk_ok(t >= 150 && t <= 158);
    tick(2);
    chk(16'(irq), 16'h0001);
    t += 2;
    wait_for(txd, 1'h0, t);
    chk_ok(t >= 158 && t <= 163);
    cfg.tx_enable_bit = 1'h0;
    tick(1);
    cfg.tx_enable_bit = 1'h1;
    wr_data(9'h0F0);
    get_frame(10, f);
    chk(f, 16'h0386);
    t = 0;
    wait_for(txd, 1'h0, t);
    chk_ok(t >= 144 && t <= 156);
    tick(200);
    set_enable(1'h0);
  endtask : t_backtoback
  task automatic t_break;
    int t;
    int k;
    cfg = '0;
    cfg.tx_enable_bit = 1'h1;
    cfg.send_break_bit = 1'h1;
    t = 0;
    wait_for(txd, 1'h0, t);
    tick(200);
    cfg.send_break_bit = 1'h0;
    t = 200;
    wait_for(txd, 1'h1, t);
    chk_ok(t >= 318 && t <= 324);
    count_low(16, k);
    chk(16'(k), 16'h0000);
    set_enable(1'h0);
  endtask : t_break
  task automatic t_collision;
    int t;
    int k;
    logic e;
    cfg = '0;
    set_enable(1'h1);
    for (int m = 0; m < 4; m++)
    begin
      cfg.bit_error_mode = 2'(m);
      e = cfg.bit_error_mode == BERR_MODE_A || cfg.bit_error_mode == BERR_MODE_B;
      wr_data(9'h0FF);
      t = 0;
      wait_for(txd, 1'h0, t);
      tick(16);
      node_low = 1'h1;
      tick(16);
      node_low = 1'h0;
      tick(8);
      chk(16'({berr, empty, done, txd}), e ? 16'h000F : 16'h0005);
      if (e)
      begin
        wr_data(9'h055);
        count_low(200, k);
        chk(16'(k), 16'h0000);
        pulse(be_clr);
        tick(2);
        chk(16'(berr), 16'h0000);
        t = 0;
        wait_for(txd, 1'h0, t);
        chk_ok(t < 40);
      end
      tick(200);
    end
    set_enable(1'h0);
    // inverted polarity on both ends: idle line must read low
    cfg.tx_polarity = 1'h1;
    cfg.rx_polarity = 1'h1;
    tick(24);
    chk(16'(txd), 16'h0000);
    cfg.tx_polarity = 1'h0;
    cfg.rx_polarity = 1'h0;
    tick(24);
  endtask : t_collision
  // last frame seen on the bus was 0xff with its first data bit pulled low
  task automatic t_rx_break;
    for (int b = 1; b >= 0; b--)
    begin
      cfg.break_detect_enable = 1'(b);
      pulse(rx_clr);
      node_low = 1'h1;
      tick(192);
      node_low = 1'h0;
      tick(48);
      if (b == 1)
        chk(16'(rx[13:1]), 16'h0FE1);
      else
        chk(16'(rx[13:3]), 16'h0003);
    end
    // start bit, two ones, then a long low: break begins mid-character
    cfg.break_detect_enable = 1'h1;
    pulse(rx_clr);
    node_low = 1'h1;
    tick(16);
    node_low = 1'h0;
    tick(32);
    node_low = 1'h1;
    tick(192);
    node_low = 1'h0;
    tick(48);
    chk(16'(rx), 16'h007A);
  endtask : t_rx_break
  ////////////////////////////////////////
  initial
  begin
    tick(6);
    rst_b = 1'h1;
    chk(16'({txd, oe, empty, done, irq, berr}), 16'h002C);
    chk(16'(rx), 16'h0000);
    t_divisor();
    t_formats();
    t_backtoback();
    t_break();
    t_collision();
    t_rx_break();
    complete_run();
  end
endmodule : uart_tx_break_collision_tb_top
